// file: core/soft_reset_nmi_regs.vh
// offsets, field positions, reset values and constants of the reset/nmi entry block
`ifndef SOFT_RESET_NMI_REGS_VH
`define SOFT_RESET_NMI_REGS_VH

// ==========================================================================
// register byte offsets
`define OFS_STATUS 5'h00
`define OFS_ERRPC_LO 5'h04
`define OFS_ERRPC_HI 5'h08
`define OFS_EVENTS 5'h0C

// ==========================================================================
// status register field positions
`define ST_ERROR_LEVEL 0
`define ST_BOOT_VECTOR 1
`define ST_TLB_SHUTDOWN 2
`define ST_SOFT_RESET 3
`define ST_NMI_SOURCE 4

// ==========================================================================
// values
`define RESET_VECTOR 64'hFFFF_FFFF_BFC0_0000
`define ERRPC_RESET 64'h0000_0000_0000_0000
`define COUNT_RESET 8'h00
`define STATUS_UNUSED_ZERO 27'h0000000

`endif

// file: core/nmi_sync.v
// two-flop synchroniser for asynchronous request pins
`timescale 1ns/100ps
`default_nettype none

module nmi_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // pins and synchronised levels
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // ========================================================================
  // per-bit chain; idle level of an active-low pin is 1
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1_reg[i] <= 1'b1;
          stage2_reg[i] <= 1'b1;
        end else begin
          stage1_reg[i] <= async_in[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2_reg;

endmodule

`default_nettype wire

// file: core/soft_reset_nmi_exception_entry.v
// exception entry for cold reset, soft reset and nonmaskable interrupt
`timescale 1ns/100ps
`default_nettype none
`include "soft_reset_nmi_regs.vh"

// How it works
// - reset with bus grant asserted during it is a cold reset.
// - reset while grant stays negated throughout is a soft reset.
// - asserting the nonmaskable request pin raises the nonmaskable exception.
// - no mask or enable ever blocks soft reset or nonmaskable entry.
// - source bit reads 1 after nonmaskable entry, 0 after soft reset.
// - both entries set the soft reset flag and use one vector.
// - entry copies the current pc into the error return pc.
// - entry sets error level and boot vector, clears tlb shutdown.
// - entry loads the pc with the 64-bit reset vector.
// - entry discards every pending cache error.
// - nothing else is changed on soft reset entry.
// - nonmaskable entry waits for an instruction boundary, aborting nothing.
// - nonmaskable entry leaves the cause register alone and jumps to handler.
// - soft reset may hit any cycle and abort multicycle work.
// - soft reset initialises only what is needed to run uncached code.
// - refill-state cache blocks may hang later cached accesses.
// - cold reset clears soft reset and tlb shutdown, sets error level, boot vector.
module soft_reset_nmi_exception_entry (
  // clock and power-on reset
  input wire clk,
  input wire arst_n,
  // system pins, active low
  input wire system_reset_in_n,
  input wire bus_grant_in_n,
  input wire nonmaskable_request_in_n,
  // pipeline side
  input wire instr_boundary,
  input wire [63:0] current_pc,
  output wire pc_load,
  output wire [63:0] pc_load_value,
  output wire core_hold,
  output wire abort_multicycle,
  output wire cache_error_discard,
  output wire nmi_taken,
  // status bits towards the core
  output wire soft_reset_flag,
  output wire error_level_flag,
  output wire boot_vector_select,
  output wire tlb_shutdown_flag,
  output wire nmi_source_flag,
  output wire [63:0] error_return_pc,
  // avalon-mm slave
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output wire [31:0] readdata,
  output wire waitrequest
);

  // ========================================================================
  // states
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_IN_RESET = 2'h1;

  reg [1:0] state_reg;
  reg grant_seen_reg;
  reg core_hold_reg;
  reg abort_reg;
  reg pc_load_reg;
  reg [63:0] pc_load_value_reg;
  reg discard_reg;
  reg nmi_taken_reg;
  reg nmi_prev_reg;
  reg nmi_pending_reg;
  reg soft_reset_reg;
  reg error_level_reg;
  reg boot_vector_reg;
  reg tlb_shutdown_reg;
  reg nmi_source_reg;
  reg [63:0] errpc_reg;
  reg [7:0] cold_count_reg;
  reg [7:0] soft_count_reg;
  reg [7:0] nmi_count_reg;
  reg [31:0] readdata_reg;
  reg waitrequest_reg;

  wire nmi_pin_sync_n;
  wire nmi_level;
  wire nmi_edge;
  wire reset_active;
  wire grant_active;
  wire enter_cold;
  wire enter_soft;
  wire enter_nmi;
  wire enter_any;
  wire bus_write;
  wire bus_read_start;
  wire [31:0] status_word;
  reg nmi_pending_next;

  // ========================================================================
  // helpers
  function hit;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] lanes;
    integer b;
    begin
      merge_bytes = old_word;
      for (b = 0; b < 4; b = b + 1) begin
        if (lanes[b]) begin
          merge_bytes[8*b +: 8] = new_word[8*b +: 8];
        end
      end
    end
  endfunction

  // ========================================================================
  // nonmaskable request capture
  // pin may be truly asynchronous, so it passes two flops first
  nmi_sync #(
    .WIDTH(1)
  ) u_nmi_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(nonmaskable_request_in_n),
    .sync_out(nmi_pin_sync_n)
  );

  assign nmi_level = ~nmi_pin_sync_n;
  assign nmi_edge = nmi_level & ~nmi_prev_reg;

  // a new request in the entry cycle survives: set wins over clear
  always @* begin
    nmi_pending_next = nmi_pending_reg;
    if (enter_any) begin
      nmi_pending_next = 1'b0;
    end
    if (nmi_edge) begin
      nmi_pending_next = 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_prev_reg <= 1'b0;
      nmi_pending_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_level;
      nmi_pending_reg <= nmi_pending_next;
    end
  end

  // ========================================================================
  // entry decision
  assign reset_active = ~system_reset_in_n;
  assign grant_active = ~bus_grant_in_n;

  // classify at release: grant seen at any time during reset means cold
  assign enter_cold = (state_reg == ST_IN_RESET) && !reset_active && grant_seen_reg;
  assign enter_soft = (state_reg == ST_IN_RESET) && !reset_active && !grant_seen_reg;
  // no mask term anywhere in these conditions
  // boundary only, so no multicycle work is cut short
  assign enter_nmi = (state_reg == ST_RUN) && !reset_active && instr_boundary &&
                     nmi_pending_reg;
  assign enter_any = enter_cold | enter_soft | enter_nmi;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RUN;
      grant_seen_reg <= 1'b0;
      core_hold_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          if (reset_active) begin
            // reset lands on any cycle and kills multicycle work
            state_reg <= ST_IN_RESET;
            grant_seen_reg <= grant_active;
            core_hold_reg <= 1'b1;
            abort_reg <= 1'b1;
          end
        end
        ST_IN_RESET: begin
          if (reset_active) begin
            // sticky over the whole reset, so a late grant still means cold
            grant_seen_reg <= grant_seen_reg | grant_active;
          end else begin
            state_reg <= ST_RUN;
            core_hold_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_RUN;
          core_hold_reg <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // pipeline redirect
  // one vector for all three entries; the core keeps its own cause state,
  // this block never drives it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_load_reg <= 1'b0;
      pc_load_value_reg <= `RESET_VECTOR;
      discard_reg <= 1'b0;
      nmi_taken_reg <= 1'b0;
    end else begin
      pc_load_reg <= enter_any;
      pc_load_value_reg <= `RESET_VECTOR;
      discard_reg <= enter_any;
      nmi_taken_reg <= enter_nmi;
    end
  end

  // ========================================================================
  // status bits and error return pc
  // only these few flops move on entry; caches, tlb and register files are
  // left alone, so a refill-state cache block may hang cached loads later
  // a write lands on the edge where the master sees waitrequest low;
  // a read is latched one edge earlier so its data stand at that edge
  assign bus_write = write && !waitrequest_reg;
  assign bus_read_start = read && waitrequest_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_reg <= 1'b0;
      tlb_shutdown_reg <= 1'b0;
      error_level_reg <= 1'b1;
      boot_vector_reg <= 1'b1;
      nmi_source_reg <= 1'b0;
      errpc_reg <= `ERRPC_RESET;
    end else if (enter_any) begin
      // hardware entry wins over a software write in the same cycle
      error_level_reg <= 1'b1;
      boot_vector_reg <= 1'b1;
      tlb_shutdown_reg <= 1'b0;
      soft_reset_reg <= ~enter_cold;
      nmi_source_reg <= enter_nmi;
      errpc_reg <= current_pc;
    end else if (bus_write) begin
      if (hit(address, `OFS_STATUS) && byteenable[0]) begin
        error_level_reg <= writedata[`ST_ERROR_LEVEL];
        boot_vector_reg <= writedata[`ST_BOOT_VECTOR];
        tlb_shutdown_reg <= writedata[`ST_TLB_SHUTDOWN];
        soft_reset_reg <= writedata[`ST_SOFT_RESET];
        nmi_source_reg <= writedata[`ST_NMI_SOURCE];
      end
      if (hit(address, `OFS_ERRPC_LO)) begin
        errpc_reg[31:0] <= merge_bytes(errpc_reg[31:0], writedata, byteenable);
      end
      if (hit(address, `OFS_ERRPC_HI)) begin
        errpc_reg[63:32] <= merge_bytes(errpc_reg[63:32], writedata, byteenable);
      end
    end
  end

  // ========================================================================
  // entry counters, wrap at 255; diagnostic only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cold_count_reg <= `COUNT_RESET;
      soft_count_reg <= `COUNT_RESET;
      nmi_count_reg <= `COUNT_RESET;
    end else begin
      if (enter_cold) begin
        cold_count_reg <= cold_count_reg + 8'h01;
      end
      if (enter_soft) begin
        soft_count_reg <= soft_count_reg + 8'h01;
      end
      if (enter_nmi) begin
        nmi_count_reg <= nmi_count_reg + 8'h01;
      end
    end
  end

  // ========================================================================
  // avalon slave: one wait state on every access
  assign status_word = {`STATUS_UNUSED_ZERO, nmi_source_reg, soft_reset_reg,
                        tlb_shutdown_reg, boot_vector_reg, error_level_reg};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      waitrequest_reg <= !((read || write) && waitrequest_reg);
      if (bus_read_start) begin
        if (hit(address, `OFS_STATUS)) begin
          readdata_reg <= status_word;
        end else if (hit(address, `OFS_ERRPC_LO)) begin
          readdata_reg <= errpc_reg[31:0];
        end else if (hit(address, `OFS_ERRPC_HI)) begin
          readdata_reg <= errpc_reg[63:32];
        end else if (hit(address, `OFS_EVENTS)) begin
          readdata_reg <= {5'h00, state_reg, nmi_pending_reg, nmi_count_reg,
                           soft_count_reg, cold_count_reg};
        end else begin
          // unmapped reads return zero, unmapped writes vanish
          readdata_reg <= 32'h00000000;
        end
      end
    end
  end

  // ========================================================================
  // outputs
  assign pc_load = pc_load_reg;
  assign pc_load_value = pc_load_value_reg;
  assign core_hold = core_hold_reg;
  assign abort_multicycle = abort_reg;
  assign cache_error_discard = discard_reg;
  assign nmi_taken = nmi_taken_reg;
  assign soft_reset_flag = soft_reset_reg;
  assign error_level_flag = error_level_reg;
  assign boot_vector_select = boot_vector_reg;
  assign tlb_shutdown_flag = tlb_shutdown_reg;
  assign nmi_source_flag = nmi_source_reg;
  assign error_return_pc = errpc_reg;
  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;

endmodule

`default_nettype wire

// file: testbench/entry_properties.sv
// concurrent checks on the reset and nmi entry block's ports
`timescale 1ns/100ps
`default_nettype none
module entry_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins and pipeline side
  input wire logic system_reset_in_n,
  input wire logic bus_grant_in_n,
  input wire logic instr_boundary,
  input wire logic [63:0] current_pc,
  input wire logic pc_load,
  input wire logic [63:0] pc_load_value,
  input wire logic core_hold,
  input wire logic abort_multicycle,
  input wire logic cache_error_discard,
  input wire logic nmi_taken,
  // status
  input wire logic soft_reset_flag,
  input wire logic error_level_flag,
  input wire logic boot_vector_select,
  input wire logic tlb_shutdown_flag,
  input wire logic nmi_source_flag,
  input wire logic [63:0] error_return_pc
);
  // ====
  // helper: grant seen while reset pin is low
  logic grant_seen_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_seen_reg <= 1'b0;
    end else begin
      grant_seen_reg <= !system_reset_in_n && (grant_seen_reg || !bus_grant_in_n);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ====
  // assertions
  a_entry_vector: assert property (
    pc_load |-> pc_load_value == 64'hFFFF_FFFF_BFC0_0000)
    else $error("pc load without reset vector");
  a_entry_flags: assert property (
    pc_load |-> error_level_flag && boot_vector_select && !tlb_shutdown_flag)
    else $error("entry status bits wrong");
  a_discard_pair: assert property (
    cache_error_discard == pc_load)
    else $error("cache error discard not paired with pc load");
  a_nmi_flags: assert property (
    nmi_taken |-> pc_load && soft_reset_flag && nmi_source_flag)
    else $error("nmi entry flags wrong");
  a_soft_source: assert property (
    pc_load && !nmi_taken |-> !nmi_source_flag)
    else $error("source bit set on reset entry");
  a_nmi_boundary: assert property (
    nmi_taken |-> $past(instr_boundary) && !$past(core_hold))
    else $error("nmi taken off a boundary");
  a_errpc_copy: assert property (
    pc_load |-> error_return_pc == $past(current_pc))
    else $error("error return pc not copied");
  a_hold_abort: assert property (
    $fell(system_reset_in_n) |=> core_hold && abort_multicycle ##1 !abort_multicycle)
    else $error("no hold or abort on reset pin");
  a_soft_or_cold: assert property (
    $rose(system_reset_in_n) && core_hold |=> pc_load && !core_hold &&
    soft_reset_flag == !$past(grant_seen_reg))
    else $error("reset release entry or class wrong");
  c_nmi: cover property (nmi_taken);
  c_cold: cover property (pc_load && !soft_reset_flag);
  c_soft: cover property (pc_load && soft_reset_flag && !nmi_source_flag);
endmodule
bind soft_reset_nmi_exception_entry entry_checker chk (.clk(clk), .arst_n(arst_n),
  .system_reset_in_n(system_reset_in_n), .bus_grant_in_n(bus_grant_in_n),
  .instr_boundary(instr_boundary), .current_pc(current_pc), .pc_load(pc_load),
  .pc_load_value(pc_load_value), .core_hold(core_hold), .abort_multicycle(abort_multicycle),
  .cache_error_discard(cache_error_discard), .nmi_taken(nmi_taken),
  .soft_reset_flag(soft_reset_flag), .error_level_flag(error_level_flag),
  .boot_vector_select(boot_vector_select), .tlb_shutdown_flag(tlb_shutdown_flag),
  .nmi_source_flag(nmi_source_flag), .error_return_pc(error_return_pc));
`default_nettype wire

// file: testbench/system_side.sv
// model of the system logic driving reset, grant and nmi pins
`timescale 1ns/100ps
`default_nettype none
module system_side (
  // clock
  input wire logic clk,
  // pins, active low
  output var logic system_reset_in_n,
  output var logic bus_grant_in_n,
  output var logic nonmaskable_request_in_n
);
  initial begin
    system_reset_in_n = 1'b1;
    bus_grant_in_n = 1'b1;
    nonmaskable_request_in_n = 1'b1;
  end
  // ====
  // reset for n cycles; for a cold one grant joins after the first edge,
  // so a cold pulse needs n above 1
  task automatic pulse_reset(input int n, input logic cold);
    system_reset_in_n <= 1'b0;
    @(posedge clk);
    if (n > 1) begin
      bus_grant_in_n <= !cold;
    end
    repeat (n - 1) @(posedge clk);
    system_reset_in_n <= 1'b1;
    bus_grant_in_n <= 1'b1;
    @(posedge clk);
  endtask
  // held low three cycles so the synchroniser cannot miss it
  task automatic nmi_pulse;
    nonmaskable_request_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    nonmaskable_request_in_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the reset and nmi entry block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_boundary = 1'b0;
  logic [63:0] current_pc = 64'h0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] rd;
  wire system_reset_in_n, bus_grant_in_n, nonmaskable_request_in_n;
  wire pc_load, core_hold, abort_multicycle, cache_error_discard, nmi_taken, waitrequest;
  wire soft_reset_flag, error_level_flag, boot_vector_select, tlb_shutdown_flag;
  wire nmi_source_flag;
  wire [63:0] pc_load_value, error_return_pc;
  wire [31:0] readdata;
  int n_mismatch = 0;
  int checks = 0;
  always #50 clk = ~clk;
  system_side sys (.clk(clk), .system_reset_in_n(system_reset_in_n),
    .bus_grant_in_n(bus_grant_in_n), .nonmaskable_request_in_n(nonmaskable_request_in_n));
  soft_reset_nmi_exception_entry dut (.clk(clk), .arst_n(arst_n),
    .system_reset_in_n(system_reset_in_n), .bus_grant_in_n(bus_grant_in_n),
    .nonmaskable_request_in_n(nonmaskable_request_in_n), .instr_boundary(instr_boundary),
    .current_pc(current_pc), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .core_hold(core_hold), .abort_multicycle(abort_multicycle),
    .cache_error_discard(cache_error_discard), .nmi_taken(nmi_taken),
    .soft_reset_flag(soft_reset_flag), .error_level_flag(error_level_flag),
    .boot_vector_select(boot_vector_select), .tlb_shutdown_flag(tlb_shutdown_flag),
    .nmi_source_flag(nmi_source_flag), .error_return_pc(error_return_pc),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest));
  // ====
  // tasks
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    check("bus wait states", 1, n);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // one idle edge, so back-to-back calls never assign read twice at once
    @(posedge clk);
  endtask
  task automatic rd_check(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  // outputs sampled on falling edges, where they are settled
  task automatic entry_check(input logic nmi, input logic sr, input logic [63:0] pc);
    int n;
    n = 0;
    @(negedge clk);
    while (pc_load !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("entry pulse", 1, pc_load);
    check("vector", 64'hFFFF_FFFF_BFC0_0000, pc_load_value);
    check("discard", 1, cache_error_discard);
    check("nmi taken", nmi, nmi_taken);
    check("flags", {nmi, sr, 3'b011},
      {nmi_source_flag, soft_reset_flag, tlb_shutdown_flag, boot_vector_select, error_level_flag});
    check("error pc", pc, error_return_pc);
    check("hold off", 0, core_hold);
    @(negedge clk);
    check("pulse ends", 0, pc_load);
    // hand back on a rising edge, where the next request may start
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ====
  // watchdog at 4000 cycles, far beyond the fewer than a hundred cycles expected
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  // ====
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_check(5'h00, 32'h0000_0003, "status at reset");
    rd_check(5'h10, 32'h0000_0000, "unmapped");
    bus(1'b1, 5'h00, 32'h0000_0004);
    rd_check(5'h00, 32'h0000_0004, "status written");
    current_pc <= 64'h0123_4567_89AB_CDEF;
    sys.pulse_reset(3, 1'b0);
    entry_check(1'b0, 1'b1, 64'h0123_4567_89AB_CDEF);
    rd_check(5'h00, 32'h0000_000B, "status soft");
    // saved state read out over the register bus, never by cached loads
    rd_check(5'h04, 32'h89AB_CDEF, "errpc low");
    rd_check(5'h08, 32'h0123_4567, "errpc high");
    // nmi must wait for a boundary, masks cleared meanwhile
    bus(1'b1, 5'h00, 32'h0000_0004);
    current_pc <= 64'hFEDC_BA98_7654_3210;
    sys.nmi_pulse();
    repeat (6) @(posedge clk);
    rd_check(5'h00, 32'h0000_0004, "nmi held");
    instr_boundary <= 1'b1;
    entry_check(1'b1, 1'b1, 64'hFEDC_BA98_7654_3210);
    instr_boundary <= 1'b0;
    rd_check(5'h00, 32'h0000_001B, "status nmi");
    current_pc <= 64'h0000_0000_0000_1000;
    sys.pulse_reset(4, 1'b1);
    entry_check(1'b0, 1'b0, 64'h0000_0000_0000_1000);
    rd_check(5'h00, 32'h0000_0003, "status cold");
    sys.pulse_reset(1, 1'b0);
    entry_check(1'b0, 1'b1, 64'h0000_0000_0000_1000);
    rd_check(5'h0C, 32'h0001_0201, "entry counts");
    print_verdict();
  end
endmodule
`default_nettype wire
